// ===== core/iww_pkg.sv
package iww_pkg;

	// counter geometry
	localparam int CNT_W = 14;
	localparam int PRE_W = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 14'h3FFF;

	// refresh byte sequence
	localparam logic [7:0] REFRESH_FIRST = 8'h00;
	localparam logic [7:0] REFRESH_SECOND = 8'hFF;

	// division ratio codes (prescale minus one per code)
	localparam logic [3:0] DIV_CODE_1 = 4'h0;
	localparam logic [3:0] DIV_CODE_16 = 4'h1;
	localparam logic [3:0] DIV_CODE_32 = 4'h2;
	localparam logic [3:0] DIV_CODE_64 = 4'h3;
	localparam logic [3:0] DIV_CODE_128 = 4'h4;
	localparam logic [3:0] DIV_CODE_256 = 4'h5;
	localparam logic [PRE_W-1:0] PRE_M1_1 = 8'h00;
	localparam logic [PRE_W-1:0] PRE_M1_16 = 8'h0F;
	localparam logic [PRE_W-1:0] PRE_M1_32 = 8'h1F;
	localparam logic [PRE_W-1:0] PRE_M1_64 = 8'h3F;
	localparam logic [PRE_W-1:0] PRE_M1_128 = 8'h7F;
	localparam logic [PRE_W-1:0] PRE_M1_256 = 8'hFF;

	// timeout reload values, indexed by timeout select
	localparam logic [CNT_W-1:0] TMO_RELOAD_0 = 14'h03FF;
	localparam logic [CNT_W-1:0] TMO_RELOAD_1 = 14'h0FFF;
	localparam logic [CNT_W-1:0] TMO_RELOAD_2 = 14'h1FFF;
	localparam logic [CNT_W-1:0] TMO_RELOAD_3 = 14'h3FFF;

	// window positions in quarters of the timeout span
	localparam logic [2:0] QTR_0 = 3'h0;
	localparam logic [2:0] QTR_1 = 3'h1;
	localparam logic [2:0] QTR_2 = 3'h2;
	localparam logic [2:0] QTR_3 = 3'h3;
	localparam logic [2:0] QTR_4 = 3'h4;

	// reset-or-interrupt select encoding
	localparam logic SEL_IRQ = 1'b0;
	localparam logic SEL_RESET = 1'b1;

	// counter control states, gray along idle -> count -> halt
	typedef enum logic [1:0] {
		IWW_IDLE = 2'b00,
		IWW_COUNT = 2'b01,
		IWW_HALT = 2'b11
	} iww_state_t;

endpackage : iww_pkg

// ===== core/iww_core.sv
`timescale 1ns/1ns
// How it works
// [RULE1] prescaler divides dedicated clock by 1..256
// [RULE2] fourteen-bit counter decrements per prescaled tick
// [RULE3] auto-start mode counts right after reset
// [RULE4] 00h then FFh refresh starts register mode
// [RULE5] reset stops counter, restores initial values
// [RULE6] sleep-stop enabled halts counting in low power
// [RULE7] register mode stops on underflow or error
// [RULE8] refresh permitted only between window positions
// [RULE9] reset output on underflow or refresh error
// [RULE10] interrupt on underflow and refresh error
// [RULE11] counter value readable as count status
// [RULE12] reset, interrupt and sleep-stop outputs exist
// [RULE13] event pulses for underflow and refresh error
// [RULE14] auto mode takes settings from boot option
// [RULE15] register mode takes control settings at refresh
// [RULE16] select zero means interrupt, one means reset
// [RULE17] nonmaskable enable picks nmi or maskable irq
// [RULE18] valid refresh reloads counter, keeps counting
// [RULE19] only FFh directly after 00h counts
module iww_core
	import iww_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dedicated_watchdog_clock,
	input wire logic auto_start_mode,
	input wire logic [3:0] boot_division_ratio_select,
	input wire logic [1:0] boot_timeout_period_select,
	input wire logic [1:0] boot_window_start_select,
	input wire logic [1:0] boot_window_end_select,
	input wire logic boot_reset_or_irq_select,
	input wire logic boot_sleep_count_stop_enable,
	input wire logic [3:0] division_ratio_select,
	input wire logic [1:0] timeout_period_select,
	input wire logic [1:0] window_start_select,
	input wire logic [1:0] window_end_select,
	input wire logic reset_or_irq_select,
	input wire logic sleep_count_stop_enable,
	input wire logic watchdog_nonmaskable_enable,
	input wire logic low_power_mode,
	input wire logic refresh_wr,
	input wire logic [7:0] refresh_data,
	output logic [CNT_W-1:0] count_status_register,
	output logic counting,
	output logic wdt_reset_out,
	output logic underflow_interrupt,
	output logic underflow_nmi,
	output logic sleep_count_stop,
	output logic evt_underflow,
	output logic evt_refresh_error
);

	// prescale minus one for a division code; unused codes fall back to 1
	function automatic logic [PRE_W-1:0] pre_m1(input logic [3:0] code);
		case (code)
			DIV_CODE_16: pre_m1 = PRE_M1_16;
			DIV_CODE_32: pre_m1 = PRE_M1_32;
			DIV_CODE_64: pre_m1 = PRE_M1_64;
			DIV_CODE_128: pre_m1 = PRE_M1_128;
			DIV_CODE_256: pre_m1 = PRE_M1_256;
			default: pre_m1 = PRE_M1_1;
		endcase
	endfunction : pre_m1

	// counter reload value for a timeout select
	function automatic logic [CNT_W-1:0] tmo_reload(input logic [1:0] sel);
		case (sel)
			2'h0: tmo_reload = TMO_RELOAD_0;
			2'h1: tmo_reload = TMO_RELOAD_1;
			2'h2: tmo_reload = TMO_RELOAD_2;
			default: tmo_reload = TMO_RELOAD_3;
		endcase
	endfunction : tmo_reload

	// count value at a number of quarters of the timeout span
	function automatic logic [CNT_W-1:0] win_pos(input logic [1:0] tsel, input logic [2:0] qtr);
		logic [CNT_W:0] quarter;
		logic [CNT_W+2:0] prod;
		quarter = ({1'b0, tmo_reload(tsel)} + 15'h0001) >> 2;
		prod = quarter * qtr;
		if (qtr == QTR_4)
			win_pos = tmo_reload(tsel);
		else
			win_pos = prod[CNT_W-1:0];
	endfunction : win_pos

	// start select to quarters: 75%, 50%, 25%, 100%
	function automatic logic [2:0] start_qtr(input logic [1:0] sel);
		case (sel)
			2'h0: start_qtr = QTR_3;
			2'h1: start_qtr = QTR_2;
			2'h2: start_qtr = QTR_1;
			default: start_qtr = QTR_4;
		endcase
	endfunction : start_qtr

	// end select to quarters: 75%, 50%, 25%, 0%
	function automatic logic [2:0] end_qtr(input logic [1:0] sel);
		case (sel)
			2'h0: end_qtr = QTR_3;
			2'h1: end_qtr = QTR_2;
			2'h2: end_qtr = QTR_1;
			default: end_qtr = QTR_0;
		endcase
	endfunction : end_qtr

	// control state
	iww_state_t state;
	iww_state_t next_state;

	// mode strap and active settings
	logic cfg_loaded;
	logic mode_auto;
	logic [3:0] act_div;
	logic [1:0] act_tmo;
	logic [1:0] act_wstart;
	logic [1:0] act_wend;
	logic act_rsel;
	logic act_sleep_count_stop_enable;

	// prescaler and down-counter
	logic [PRE_W-1:0] presc;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// refresh sequence and clock edge tracking
	logic armed;
	logic clk_prev;

	// watchdog clock edge, seen at the first core edge that finds the clock high
	wire clk_rise = dedicated_watchdog_clock & ~clk_prev;

	// counting is held off in low power when sleep-stop is on
	wire cnt_stop = act_sleep_count_stop_enable & low_power_mode; // [RULE6]
	wire in_count = (state == IWW_COUNT);
	wire run = in_count & ~cnt_stop;

	// prescaled tick and underflow at count zero
	wire [PRE_W-1:0] pre_last = pre_m1(act_div);
	wire pre_tick = run & clk_rise & (presc == pre_last);
	wire underflow = pre_tick & (count == '0);

	// an FFh write counts only right after a 00h write
	wire refresh = refresh_wr & armed & (refresh_data == REFRESH_SECOND);

	// permitted span lies between the start and end positions
	wire [CNT_W-1:0] ws_pos = win_pos(act_tmo, start_qtr(act_wstart));
	wire [CNT_W-1:0] we_pos = win_pos(act_tmo, end_qtr(act_wend));
	wire in_window = (count <= ws_pos) & (count >= we_pos); // [RULE8]

	// refresh outcome while counting or stopped
	wire refresh_ok = refresh & in_count & in_window;
	wire refresh_err = refresh & in_count & ~in_window;
	wire refresh_start = refresh & ~in_count & cfg_loaded & ~mode_auto;
	wire fault = underflow | refresh_err;

	// faults steered by the select bit, nmi or maskable by live enable
	wire route_reset = fault & (act_rsel == SEL_RESET);
	wire route_irq = fault & (act_rsel == SEL_IRQ);

	// settings used to start from a refresh in register mode
	wire [1:0] start_tmo = (state == IWW_IDLE) ? timeout_period_select : act_tmo;
	wire [CNT_W-1:0] start_reload = tmo_reload(start_tmo);

	// reload for the active timeout, auto-start and prescaler restart
	wire [CNT_W-1:0] reload_val = tmo_reload(act_tmo);
	wire auto_go = (state == IWW_IDLE) & cfg_loaded & mode_auto;
	wire pre_clear = refresh_start | refresh_ok | fault | ~run;

	// counter state transitions
	always_comb
	begin
		next_state = state;
		case (state)
			IWW_IDLE:
			begin
				if (cfg_loaded & mode_auto)
					next_state = IWW_COUNT; // [RULE3]
				else if (refresh_start)
					next_state = IWW_COUNT; // [RULE4]
			end
			IWW_COUNT:
			begin
				if (fault & ~mode_auto)
					next_state = IWW_HALT; // [RULE7]
			end
			IWW_HALT:
			begin
				if (refresh_start)
					next_state = IWW_COUNT;
			end
			default: next_state = IWW_IDLE;
		endcase
	end

	// counter next value
	always_comb
	begin
		next_count = count;
		if (auto_go)
			next_count = reload_val; // [RULE3]
		else if (refresh_start)
			next_count = start_reload; // [RULE4]
		else if (refresh_ok)
			next_count = reload_val; // [RULE18]
		else if (underflow & mode_auto)
			next_count = reload_val;
		else if (refresh_err & mode_auto)
			next_count = reload_val;
		else if (pre_tick & (count != '0))
			next_count = count - 14'h0001; // [RULE2]
	end

	// state and counter
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state <= IWW_IDLE; // [RULE5]
			count <= CNT_RESET;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	// previous level of the watchdog clock for edge detection
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			clk_prev <= 1'b0;
		else
			clk_prev <= dedicated_watchdog_clock;
	end

	// prescaler, restarted whenever the counter is (re)loaded
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			presc <= '0;
		else if (pre_clear)
			presc <= '0;
		else if (clk_rise)
			presc <= (presc == pre_last) ? '0 : presc + 8'h01; // [RULE1]
	end

	// refresh sequence tracker: only 00h arms, anything else disarms
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			armed <= 1'b0;
		else if (refresh_wr)
			armed <= (refresh_data == REFRESH_FIRST); // [RULE19]
	end

	// mode strap and settings, caught in the first cycle after reset and, in register mode, again at the refresh that starts from idle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cfg_loaded <= 1'b0;
			mode_auto <= 1'b0;
			act_div <= DIV_CODE_1;
			act_tmo <= 2'h3;
			act_wstart <= 2'h3;
			act_wend <= 2'h3;
			act_rsel <= SEL_IRQ;
			act_sleep_count_stop_enable <= 1'b0;
		end
		else if (!cfg_loaded)
		begin
			cfg_loaded <= 1'b1;
			mode_auto <= auto_start_mode;
			act_rsel <= auto_start_mode ? boot_reset_or_irq_select : reset_or_irq_select;
			act_sleep_count_stop_enable <= auto_start_mode ? boot_sleep_count_stop_enable
				: sleep_count_stop_enable; // [RULE6]
			if (auto_start_mode)
			begin
				act_div <= boot_division_ratio_select; // [RULE14]
				act_tmo <= boot_timeout_period_select;
				act_wstart <= boot_window_start_select;
				act_wend <= boot_window_end_select;
			end
		end
		else if (refresh_start & (state == IWW_IDLE))
		begin
			act_div <= division_ratio_select; // [RULE15]
			act_tmo <= timeout_period_select;
			act_wstart <= window_start_select;
			act_wend <= window_end_select;
			act_rsel <= reset_or_irq_select;
			act_sleep_count_stop_enable <= sleep_count_stop_enable;
		end
	end

	// fault outputs: one-cycle pulses, reset and interrupts steered by the select bit
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wdt_reset_out <= 1'b0;
			underflow_interrupt <= 1'b0;
			underflow_nmi <= 1'b0;
			evt_underflow <= 1'b0;
			evt_refresh_error <= 1'b0;
		end
		else
		begin
			wdt_reset_out <= route_reset; // [RULE9] [RULE16]
			underflow_interrupt <= route_irq & ~watchdog_nonmaskable_enable; // [RULE10] [RULE17]
			underflow_nmi <= route_irq & watchdog_nonmaskable_enable; // [RULE17]
			evt_underflow <= underflow; // [RULE13]
			evt_refresh_error <= refresh_err; // [RULE13]
		end
	end

	// count status shows the value after this cycle's update
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			count_status_register <= CNT_RESET;
		else
			count_status_register <= next_count; // [RULE11]
	end

	// counting and sleep-stop control levels
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			counting <= 1'b0;
			sleep_count_stop <= 1'b0;
		end
		else
		begin
			counting <= (next_state == IWW_COUNT);
			sleep_count_stop <= act_sleep_count_stop_enable; // [RULE12]
		end
	end

endmodule : iww_core

// ===== tb/iww_core_asserts.sv
`timescale 1ns/1ns
// watches the watchdog outputs against their causes at the ports
module iww_core_asserts
	import iww_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic watchdog_nonmaskable_enable,
	input wire logic low_power_mode,
	input wire logic refresh_wr,
	input wire logic [CNT_W-1:0] count_status_register,
	input wire logic counting,
	input wire logic wdt_reset_out,
	input wire logic underflow_interrupt,
	input wire logic underflow_nmi,
	input wire logic sleep_count_stop,
	input wire logic evt_underflow,
	input wire logic evt_refresh_error
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// fault and action pulses, grouped for the pairing checks
	wire fault = evt_underflow || evt_refresh_error;
	wire action = wdt_reset_out || underflow_interrupt || underflow_nmi;
	a_reset_init: assert property (rst_n && !$past(rst_n) |->
		count_status_register == 14'h3FFF && !counting) else $error("bad state after reset");
	a_nmi_route: assert property (underflow_nmi |-> $past(watchdog_nonmaskable_enable))
		else $error("nmi while enable low");
	a_irq_route: assert property (underflow_interrupt |-> !$past(watchdog_nonmaskable_enable))
		else $error("irq while enable high");
	a_pulse_once: assert property (fault |=> !evt_underflow && !evt_refresh_error)
		else $error("event pulse too long");
	a_fault_action: assert property (fault |-> action) else $error("fault without output");
	a_action_cause: assert property (action |-> fault) else $error("output without fault");
	a_count_step: assert property ($past(counting) && !$past(refresh_wr) && !evt_underflow &&
		$changed(count_status_register) |-> count_status_register == $past(count_status_register) - 14'h1)
		else $error("count not stepping by one");
	a_idle_hold: assert property (!counting && !$past(counting) && !$past(refresh_wr) |->
		$stable(count_status_register)) else $error("count moved while stopped");
	a_sleep_freeze: assert property ($past(low_power_mode) && $past(low_power_mode, 2) &&
		$past(sleep_count_stop, 2) && !$past(refresh_wr) |-> $stable(count_status_register))
		else $error("count moved in sleep");
	c_underflow: cover property (evt_underflow);
	c_refresh_error: cover property (evt_refresh_error);
	c_nmi: cover property (underflow_nmi);
endmodule : iww_core_asserts

bind iww_core iww_core_asserts i_iww_core_asserts (.core_clk(core_clk), .rst_n(rst_n),
	.watchdog_nonmaskable_enable(watchdog_nonmaskable_enable), .low_power_mode(low_power_mode),
	.refresh_wr(refresh_wr), .count_status_register(count_status_register), .counting(counting),
	.wdt_reset_out(wdt_reset_out), .underflow_interrupt(underflow_interrupt),
	.underflow_nmi(underflow_nmi), .sleep_count_stop(sleep_count_stop),
	.evt_underflow(evt_underflow), .evt_refresh_error(evt_refresh_error));

// ===== tb/iww_core_test.sv
`timescale 1ns/1ns
module iww_core_test;
	import iww_pkg::*;
	logic core_clk = 0, rst_n = 0, wdc = 0, am = 1, nmi_en = 0, lp = 0, rwr = 0;
	logic rsel = 1'b1, slp = 1'b1;
	logic [7:0] rdat = 8'h00;
	logic [3:0] div = 4'h0;
	logic [1:0] tmo = 2'h0, ws = 2'h3, we = 2'h3;
	logic [CNT_W-1:0] cnt;
	logic cnting, rst_o, irq, nmi, slp_o, e_uf, e_err;
	int fail_count = 0, total_checks = 0, n_uf = 0, n_err = 0, n_rst = 0, n_irq = 0, n_nmi = 0;
	// boot option word and control register share the same stimulus
	iww_core i_iww_core (.core_clk(core_clk), .rst_n(rst_n), .dedicated_watchdog_clock(wdc),
		.auto_start_mode(am), .boot_division_ratio_select(div), .boot_timeout_period_select(tmo),
		.boot_window_start_select(ws), .boot_window_end_select(we),
		.boot_reset_or_irq_select(rsel), .boot_sleep_count_stop_enable(slp),
		.division_ratio_select(div), .timeout_period_select(tmo), .window_start_select(ws),
		.window_end_select(we), .reset_or_irq_select(rsel), .sleep_count_stop_enable(slp),
		.watchdog_nonmaskable_enable(nmi_en), .low_power_mode(lp), .refresh_wr(rwr),
		.refresh_data(rdat), .count_status_register(cnt), .counting(cnting),
		.wdt_reset_out(rst_o), .underflow_interrupt(irq), .underflow_nmi(nmi),
		.sleep_count_stop(slp_o), .evt_underflow(e_uf), .evt_refresh_error(e_err));
	initial forever #4 core_clk = ~core_clk;
	// tally one-cycle output pulses
	always @(posedge core_clk)
	begin
		n_uf <= n_uf + e_uf;
		n_err <= n_err + e_err;
		n_rst <= n_rst + rst_o;
		n_irq <= n_irq + irq;
		n_nmi <= n_nmi + nmi;
	end
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// watchdog clock edges, slower than half the core clock
	task tick(input int n);
		repeat (n)
		begin
			wdc = 1;
			cyc(2);
			wdc = 0;
			cyc(2);
		end
		cyc(3);
	endtask : tick
	task wr(input logic [7:0] d);
		rwr = 1;
		rdat = d;
		cyc(1);
		rwr = 0;
		cyc(1);
	endtask : wr
	task refresh;
		wr(8'h00);
		wr(8'hFF);
	endtask : refresh
	task reset_dut(input logic a);
		am = a;
		rst_n = 0;
		cyc(20);
		rst_n = 1;
		cyc(3);
	endtask : reset_dut
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial
	begin
		#400000;
		fail_count++;
		summarize;
	end
	initial
	begin
		cyc(1);
		reset_dut(1);
		chk(cnting, 14'h1);
		chk(cnt, 14'h03FF);
		tick(16);
		chk(cnt, 14'h03EF);
		tick(14'h03EF);
		chk(cnt, 14'h0000);
		tick(1);
		chk(n_uf, 14'h1);
		chk(n_rst, 14'h1);
		chk(cnt, 14'h03FF);
		lp = 1;
		tick(5);
		chk(cnt, 14'h03FF);
		chk(slp_o, 14'h1);
		lp = 0;
		tick(5);
		chk(cnt, 14'h03FA);
		div = 4'h1;
		slp = 0;
		reset_dut(0);
		tick(3);
		chk(cnting, 14'h0);
		chk(cnt, 14'h3FFF);
		refresh;
		chk(cnting, 14'h1);
		chk(cnt, 14'h03FF);
		tick(40);
		chk(cnt, 14'h03FD);
		wr(8'h00);
		wr(8'h22);
		wr(8'hFF);
		chk(cnt, 14'h03FD);
		refresh;
		chk(cnt, 14'h03FF);
		div = 4'h0;
		ws = 2'h2;
		rsel = 0;
		nmi_en = 1;
		reset_dut(0);
		refresh;
		refresh;
		chk(n_err, 14'h1);
		chk(n_nmi, 14'h1);
		chk(cnting, 14'h0);
		nmi_en = 0;
		refresh;
		tick(14'h0300);
		chk(cnt, 14'h00FF);
		refresh;
		chk(n_err, 14'h1);
		chk(cnt, 14'h03FF);
		tick(14'h0400);
		chk(n_irq, 14'h1);
		chk(n_rst, 14'h1);
		chk(cnting, 14'h0);
		summarize;
	end
endmodule : iww_core_test
